// ---- hdl/ofd_decoder.sv ----
/*
   Opcode field decoder: turns instruction words into datapath controls,
   keeps bank select, table pointer, table latch and status flags.
   Assumes fetch logic on the same clock supplies the word format.
*/
// The AXI4-Lite register port and the address map were chosen for this implementation.
// Behaviour
// - Access bit 0 picks the access RAM and ignores the bank select, 1 uses the bank select.
// - Destination bit 0 sends the result to the accumulator, 1 to the file register.
// - Bit field picks one bit, 0 to 7, of the addressed 8-bit file register.
// - File field is an 8-bit address, or a 2-bit indirect pointer designator for pointer loads.
// - The register move takes a 12-bit source and a 12-bit destination with no banking.
// - The literal is 8, 12 or 20 bits wide depending on the instruction.
// - Table accesses keep, post-increment, post-decrement or pre-increment the pointer.
// - Relative branches use a two's complement offset, call and goto a direct address.
// - Fast bit 0 leaves the shadow registers alone, 1 saves on call or restores on return.
// - The table unit holds a 21-bit program pointer and an 8-bit byte latch.
// - Don't-care instruction bits never change decoding; tools should emit them as 0.
// - Indexed moves add a 7-bit source and a 7-bit destination offset to the indirect pointer.
// - Carry, digit carry, zero, overflow and negative flags are kept and updated by results.
// - A lone second word with its top four bits all 1 decodes as a no-operation.
`timescale 1ns/1ps
module ofd_decoder #(
   parameter int               BANK_W    = 4,
   parameter logic [7:0]       ACC_SPLIT = 8'h80,
   parameter logic [1:0]       IDX_PTR   = 2'h2
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [ofd_pkg::AXI_AW-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [ofd_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [ofd_pkg::AXI_AW-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [ofd_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          fetch_valid,
   input  wire ofd_pkg::ofd_fetch_t           fetch,
   input  wire logic [3:0][ofd_pkg::ADDR_W-1:0] indirect_pointer,
   input  wire logic [ofd_pkg::NFLAGS-1:0]    alu_flag_we,
   input  wire logic [ofd_pkg::NFLAGS-1:0]    alu_flag_val,
   input  wire logic [ofd_pkg::LATCH_W-1:0]   prog_rd_data,
   input  wire logic                          prog_rd_valid,
   output logic                               dec_valid,
   output ofd_pkg::ofd_dec_t                  dec,
   output logic [BANK_W-1:0]                  bank_select_register,
   output logic [ofd_pkg::NFLAGS-1:0]         status_flags,
   output logic [ofd_pkg::TPTR_W-1:0]         table_pointer,
   output logic [ofd_pkg::LATCH_W-1:0]        table_byte_latch,
   output logic [ofd_pkg::TPTR_W-1:0]         prog_addr,
   output logic                               prog_rd,
   output logic                               prog_wr,
   output logic [ofd_pkg::LATCH_W-1:0]        prog_wr_data
);
   import ofd_pkg::*;

   typedef enum logic [1:0] {ST_FIRST = 2'b01, ST_SECOND = 2'b10} ofd_state_t;

   function automatic logic is_two_word(input ofd_fmt_t f);
      return f == FMT_MOVFF || f == FMT_LFSR || f == FMT_GOTO ||
             f == FMT_CALL || f == FMT_IDXMOV;
   endfunction

   ofd_state_t        state;
   logic [WORD_W-1:0] first_word;
   ofd_fmt_t          pend_fmt;
   ofd_dec_t          next_dec;
   logic              last_nop;

   wire [WORD_W-1:0] w       = fetch.word;
   wire              marked  = w[WORD_W-1:POS_MARK] == SECOND_MARK;
   wire              in_two  = state == ST_SECOND;
   wire ofd_fmt_t    eff_fmt = in_two ? pend_fmt : fetch.fmt;
   wire [WORD_W-1:0] w1      = in_two ? first_word : w;
   wire              lone2nd = !in_two && marked;
   wire              bad2nd  = in_two && !marked;
   wire              starts2 = !in_two && !marked && is_two_word(fetch.fmt);
   wire              emit    = fetch_valid && !starts2;

   // Bank resolution; the access RAM splits into low and high pages
   wire [FILE_W-1:0] f8       = w1[FILE_W-1:0];
   wire [3:0]        acc_bank = (f8 < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK;
   wire [ADDR_W-1:0] banked   = w1[POS_A] ? {4'(bank_select_register), f8}
                                          : {acc_bank, f8};
   wire [ADDR_W-1:0] idx_base = indirect_pointer[IDX_PTR];

   // Only the documented field bits are read; all others are don't-care
   always_comb
   begin
      next_dec           = '0;
      next_dec.fmt       = eff_fmt;
      next_dec.nop       = lone2nd || bad2nd || eff_fmt == FMT_NONE;
      next_dec.tbl_write = fetch.tbl_write;
      if (!next_dec.nop)
      begin
         case (eff_fmt)
            FMT_BYTE:
            begin
               next_dec.file_addr = banked;
               next_dec.dest_file = w[POS_D];
            end
            FMT_BIT:
            begin
               next_dec.file_addr = banked;
               next_dec.bit_pos   = w[POS_BIT+:3];
               next_dec.bit_mask  = 8'h01 << w[POS_BIT+:3];
            end
            FMT_LIT8:
            begin
               next_dec.literal = LIT_W'(w[7:0]);
               next_dec.lit_w   = LW_8;
            end
            FMT_MOVFF:
            begin
               next_dec.src_addr = w1[ADDR_W-1:0];
               next_dec.dst_addr = w[ADDR_W-1:0];
            end
            FMT_LFSR:
            begin
               next_dec.ptr_sel = w1[POS_PTR+:2];
               next_dec.literal = LIT_W'({w1[3:0], w[7:0]});
               next_dec.lit_w   = LW_12;
            end
            FMT_GOTO, FMT_CALL:
            begin
               next_dec.literal  = {w[ADDR_W-1:0], w1[7:0]};
               next_dec.lit_w    = LW_20;
               next_dec.br_value = TPTR_W'({w[ADDR_W-1:0], w1[7:0]});
               next_dec.shadow_save = eff_fmt == FMT_CALL && w1[POS_SCAL];
            end
            FMT_BRA11:
            begin
               next_dec.br_rel   = 1'b1;
               next_dec.br_value = TPTR_W'($signed(w[10:0]));
            end
            FMT_BR8:
            begin
               next_dec.br_rel   = 1'b1;
               next_dec.br_value = TPTR_W'($signed(w[7:0]));
            end
            FMT_RET:
               next_dec.shadow_restore = w[POS_SRET];
            FMT_TBL:
               next_dec.tmode = ofd_tmode_t'(w[1:0]);
            FMT_IDXMOV:
            begin
               next_dec.src_addr = idx_base + ADDR_W'(w1[OFS_W-1:0]);
               next_dec.dst_addr = idx_base + ADDR_W'(w[OFS_W-1:0]);
            end
            default:
               next_dec.nop = 1'b1;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= ST_FIRST;
         first_word <= '0;
         pend_fmt   <= FMT_NONE;
         dec_valid  <= 1'b0;
         dec        <= '0;
         last_nop   <= 1'b0;
      end
      else
      begin
         dec_valid <= emit;
         if (emit)
         begin
            dec      <= next_dec;
            last_nop <= next_dec.nop;
         end
         if (fetch_valid)
         begin
            case (state)
               ST_FIRST:
                  if (starts2)
                  begin
                     first_word <= w;
                     pend_fmt   <= fetch.fmt;
                     state      <= ST_SECOND;
                  end
               ST_SECOND:
                  state <= ST_FIRST;
               default:
                  state <= ST_FIRST;
            endcase
         end
      end
   end

   // Table access unit
   wire tbl_go = emit && !next_dec.nop && eff_fmt == FMT_TBL;
   logic [TPTR_W-1:0] tbl_access;
   logic [TPTR_W-1:0] tbl_next;

   ofd_tbl_ptr #(.W(TPTR_W)) u_tbl_ptr (
      .mode        (next_dec.tmode),
      .ptr         (table_pointer),
      .access_addr (tbl_access),
      .next_ptr    (tbl_next)
   );

   // AXI4-Lite slave
   logic              aw_held;
   logic              w_held;
   logic [AXI_AW-1:0] aw_addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0]        wstrb_q;

   function automatic logic [DATA_W:0] reg_read(input logic [AXI_AW-1:0] a);
      logic [DATA_W-1:0] d;
      d = '0;
      if (a == REG_BANK)
         return {1'b1, DATA_W'(bank_select_register)};
      else if (a == REG_TPTR)
         return {1'b1, DATA_W'(table_pointer)};
      else if (a == REG_TLAT)
         return {1'b1, DATA_W'(table_byte_latch)};
      else if (a == REG_FLAGS)
         return {1'b1, DATA_W'(status_flags)};
      else if (a == REG_DSTAT)
      begin
         d[ADDR_W-1:0] = dec.file_addr;
         d[DSTAT_PEND] = in_two;
         d[DSTAT_NOP]  = last_nop;
         return {1'b1, d};
      end
      return {1'b0, d};
   endfunction

   logic [DATA_W:0]   wr_cur, rd_sel;
   wire               do_write = aw_held && w_held && !s_axi_bvalid;
   wire [DATA_W-1:0]  wmerged;

   // A process so that register changes, not only address changes, re-evaluate
   always_comb
   begin
      wr_cur = reg_read(aw_addr_q);
      rd_sel = reg_read(s_axi_araddr);
   end

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_lane
         assign wmerged[8*lane+:8] = wstrb_q[lane] ? wdata_q[8*lane+:8]
                                                  : wr_cur[8*lane+:8];
      end
   endgenerate

   wire wr_bank  = do_write && aw_addr_q == REG_BANK;
   wire wr_tptr  = do_write && aw_addr_q == REG_TPTR;
   wire wr_tlat  = do_write && aw_addr_q == REG_TLAT;
   wire wr_flags = do_write && aw_addr_q == REG_FLAGS;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr_q    <= '0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held  <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_cur[DATA_W] ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_sel[DATA_W-1:0];
            s_axi_rresp  <= rd_sel[DATA_W] ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Hardware updates win over a software write in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bank_select_register <= '0;
         table_pointer        <= '0;
         table_byte_latch     <= '0;
         status_flags         <= '0;
         prog_addr            <= '0;
         prog_rd              <= 1'b0;
         prog_wr              <= 1'b0;
         prog_wr_data         <= '0;
      end
      else
      begin
         if (wr_bank)
            bank_select_register <= wmerged[BANK_W-1:0];
         prog_rd <= tbl_go && !fetch.tbl_write;
         prog_wr <= tbl_go && fetch.tbl_write;
         if (tbl_go)
         begin
            table_pointer <= tbl_next;
            prog_addr     <= tbl_access;
            prog_wr_data  <= table_byte_latch;
         end
         else if (wr_tptr)
            table_pointer <= wmerged[TPTR_W-1:0];
         if (prog_rd_valid)
            table_byte_latch <= prog_rd_data;
         else if (wr_tlat)
            table_byte_latch <= wmerged[LATCH_W-1:0];
         for (int i = 0; i < NFLAGS; i++)
         begin
            if (alu_flag_we[i])
               status_flags[i] <= alu_flag_val[i];
            else if (wr_flags)
               status_flags[i] <= wmerged[i];
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire fv_one = fetch_valid && !in_two && !marked;

   a_access_bank: assert property (fv_one && fetch.fmt == FMT_BYTE && !w[POS_A]
      && w[7:0] < ACC_SPLIT |=> dec_valid && dec.file_addr == {ACC_LOW_BANK, $past(w[7:0])})
      else $error("access bank address wrong");
   a_bank_select: assert property (fv_one && fetch.fmt == FMT_BIT && w[POS_A]
      |=> dec.file_addr[ADDR_W-1:FILE_W] == 4'($past(bank_select_register)))
      else $error("bank select not applied");
   a_dest_route: assert property (fv_one && fetch.fmt == FMT_BYTE
      |=> dec.dest_file == $past(w[POS_D]))
      else $error("destination bit lost");
   a_bit_mask: assert property (fv_one && fetch.fmt == FMT_BIT
      |=> dec.bit_mask == 8'h01 << $past(w[POS_BIT+:3]) && $onehot(dec.bit_mask))
      else $error("bit mask wrong");
   a_move_pair: assert property (fv_one && fetch.fmt == FMT_MOVFF ##1
      fetch_valid && marked |=> dec_valid && !dec.nop
      && dec.src_addr == $past(first_word[ADDR_W-1:0]) && dec.dst_addr == $past(w[ADDR_W-1:0]))
      else $error("move addresses wrong");
   a_lit_eight: assert property (fv_one && fetch.fmt == FMT_LIT8
      |=> dec.literal == LIT_W'($past(w[7:0])) && dec.lit_w == LW_8)
      else $error("8-bit literal wrong");
   a_tbl_postinc: assert property (tbl_go && next_dec.tmode == TM_POSTINC
      |=> table_pointer == $past(table_pointer) + TPTR_W'(1) && prog_addr == $past(table_pointer))
      else $error("post-increment wrong");
   a_rel_branch: assert property (fv_one && fetch.fmt == FMT_BR8 && w[7]
      |=> dec.br_rel && dec.br_value[TPTR_W-1:8] == '1)
      else $error("relative offset not sign extended");
   a_fast_return: assert property (fv_one && fetch.fmt == FMT_RET
      |=> dec.shadow_restore == $past(w[POS_SRET]) && !dec.shadow_save)
      else $error("fast return bit wrong");
   a_flag_update: assert property (alu_flag_we[FLG_Z]
      |=> status_flags[FLG_Z] == $past(alu_flag_val[FLG_Z]))
      else $error("zero flag not updated");
   a_lone_second: assert property (fetch_valid && lone2nd
      |=> dec_valid && dec.nop)
      else $error("lone second word not a no-operation");
   a_write_resp: assert property (do_write |=> s_axi_bvalid)
      else $error("write response dropped");

   c_two_word: cover property (fv_one && fetch.fmt == FMT_CALL ##1 fetch_valid && marked);
   c_tbl_read: cover property (prog_rd ##[1:8] prog_rd_valid);
   c_axi_write: cover property (do_write && aw_addr_q == REG_BANK);
endmodule // ofd_decoder

// ---- hdl/ofd_pkg.sv ----
/*
   Shared constants and types for the opcode field decoder.
   Assumes one 50 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package ofd_pkg;
   localparam int WORD_W   = 16;
   localparam int ADDR_W   = 12;
   localparam int FILE_W   = 8;
   localparam int LIT_W    = 20;
   localparam int TPTR_W   = 21;
   localparam int LATCH_W  = 8;
   localparam int NFLAGS   = 5;
   localparam int OFS_W    = 7;
   localparam int DATA_W   = 32;
   localparam int AXI_AW   = 8;
   // Field positions inside an instruction word
   localparam int POS_A    = 8;
   localparam int POS_D    = 9;
   localparam int POS_BIT  = 9;
   localparam int POS_SCAL = 8;
   localparam int POS_SRET = 0;
   localparam int POS_PTR  = 4;
   localparam int POS_MARK = 12;
   localparam logic [3:0] SECOND_MARK = 4'hF;
   // Register map
   localparam logic [AXI_AW-1:0] REG_BANK  = 8'h00;
   localparam logic [AXI_AW-1:0] REG_TPTR  = 8'h04;
   localparam logic [AXI_AW-1:0] REG_TLAT  = 8'h08;
   localparam logic [AXI_AW-1:0] REG_FLAGS = 8'h0C;
   localparam logic [AXI_AW-1:0] REG_DSTAT = 8'h10;
   localparam int DSTAT_PEND = 16;
   localparam int DSTAT_NOP  = 17;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;

   typedef enum logic [3:0] {
      FMT_NONE, FMT_BYTE, FMT_BIT, FMT_LIT8, FMT_MOVFF, FMT_LFSR, FMT_GOTO,
      FMT_CALL, FMT_BRA11, FMT_BR8, FMT_RET, FMT_TBL, FMT_IDXMOV
   } ofd_fmt_t;

   typedef enum logic [1:0] {
      TM_KEEP    = 2'b00,
      TM_POSTINC = 2'b01,
      TM_POSTDEC = 2'b10,
      TM_PREINC  = 2'b11
   } ofd_tmode_t;

   typedef enum logic [1:0] {LW_8, LW_12, LW_20} ofd_litw_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      ofd_fmt_t          fmt;
      logic              tbl_write;
   } ofd_fetch_t;

   typedef struct packed {
      logic              nop;
      ofd_fmt_t          fmt;
      logic [ADDR_W-1:0] file_addr;
      logic              dest_file;
      logic [2:0]        bit_pos;
      logic [7:0]        bit_mask;
      logic [LIT_W-1:0]  literal;
      ofd_litw_t         lit_w;
      logic [1:0]        ptr_sel;
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
      logic              br_rel;
      logic [TPTR_W-1:0] br_value;
      logic              shadow_save;
      logic              shadow_restore;
      ofd_tmode_t        tmode;
      logic              tbl_write;
   } ofd_dec_t;
endpackage

// ---- hdl/ofd_tbl_ptr.sv ----
/*
   Table pointer update unit: access address and next pointer value.
   Assumes the caller registers both results.
*/
`timescale 1ns/1ps
module ofd_tbl_ptr #(
   parameter int W = ofd_pkg::TPTR_W
) (
   input  wire ofd_pkg::ofd_tmode_t mode,
   input  wire logic [W-1:0]        ptr,
   output logic [W-1:0]             access_addr,
   output logic [W-1:0]             next_ptr
);
   import ofd_pkg::*;
   wire [W-1:0] ptr_inc = ptr + W'(1);
   wire [W-1:0] ptr_dec = ptr - W'(1);

   assign access_addr = (mode == TM_PREINC) ? ptr_inc : ptr;
   assign next_ptr    = (mode == TM_POSTINC || mode == TM_PREINC) ? ptr_inc :
                        (mode == TM_POSTDEC) ? ptr_dec : ptr;
endmodule // ofd_tbl_ptr

// ---- tb/ofd_prog_model.sv ----
/*
   Program memory model that answers table reads after a random delay.
   Assumes prog_rd is a one-cycle pulse with prog_addr valid.
*/
`timescale 1ns/1ps
module ofd_prog_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        prog_rd,
   input  wire logic [20:0] prog_addr,
   output logic [7:0]       prog_rd_data,
   output logic             prog_rd_valid
);
   logic [1:0] wait_cnt;
   logic [7:0] byte_q;
   logic       busy;
   // Idle data toggles so a stale byte never passes for a fresh one
   always_ff @(posedge aclk)
   begin
      prog_rd_valid <= 1'b0;
      prog_rd_data  <= ~prog_rd_data;
      if (!aresetn)
      begin
         busy         <= 1'b0;
         prog_rd_data <= 8'h00;
      end
      else if (prog_rd)
      begin
         busy     <= 1'b1;
         wait_cnt <= 2'($urandom_range(2));
         byte_q   <= prog_addr[7:0] ^ 8'hA5;
      end
      else if (busy && wait_cnt == 2'h0)
      begin
         busy          <= 1'b0;
         prog_rd_valid <= 1'b1;
         prog_rd_data  <= byte_q;
      end
      else if (busy)
         wait_cnt <= wait_cnt - 2'h1;
   end
endmodule // ofd_prog_model

// ---- tb/opcode_field_decoder_tb.sv ----
/*
   Self-checking bench for the opcode field decoder.
   Assumes ofd_prog_model serves table reads.
*/
`timescale 1ns/1ps
module opcode_field_decoder_tb;
   import ofd_pkg::*;
   localparam logic [1:0] IDX = 2'h2;
   logic aclk, aresetn, awv, wv, bready, arv, rready, fv, awready, wready, bvalid;
   logic arready, rvalid, dec_valid, prog_rd, prog_wr, rd_valid;
   logic [7:0] awaddr, araddr, tlat, rd_data, wr_data;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [3:0][11:0] iptr;
   logic [4:0] fwe, fval, flags, ef;
   logic [3:0] bank, bsel;
   logic [20:0] tptr, paddr;
   ofd_fetch_t fetch;
   ofd_dec_t dec;
   int error_cnt, checked, cyc, i;
   ofd_fmt_t fl[6] = '{FMT_BYTE, FMT_BIT, FMT_LIT8, FMT_BRA11, FMT_BR8, FMT_RET};
   ofd_fmt_t tl[5] = '{FMT_MOVFF, FMT_LFSR, FMT_GOTO, FMT_CALL, FMT_IDXMOV};

   ofd_decoder #(.BANK_W(4), .ACC_SPLIT(8'h80), .IDX_PTR(IDX)) i_ofd_decoder (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_valid(fv),
      .fetch(fetch), .indirect_pointer(iptr), .alu_flag_we(fwe), .alu_flag_val(fval),
      .prog_rd_data(rd_data), .prog_rd_valid(rd_valid), .dec_valid(dec_valid), .dec(dec),
      .bank_select_register(bank), .status_flags(flags), .table_pointer(tptr),
      .table_byte_latch(tlat), .prog_addr(paddr), .prog_rd(prog_rd), .prog_wr(prog_wr),
      .prog_wr_data(wr_data));
   ofd_prog_model i_ofd_prog_model (.aclk(aclk), .aresetn(aresetn), .prog_rd(prog_rd),
      .prog_addr(paddr), .prog_rd_data(rd_data), .prog_rd_valid(rd_valid));

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata  <= v;
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awv && awready)
            awv <= 1'b0;
         if (wv && wready)
            wv <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arv    <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arv && arready)
            arv <= 1'b0;
      end while (rvalid !== 1'b1);
      v  = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   function automatic logic two(ofd_fmt_t f);
      return f inside {FMT_MOVFF, FMT_LFSR, FMT_GOTO, FMT_CALL, FMT_IDXMOV};
   endfunction

   function automatic logic [31:0] key(ofd_fmt_t f, ofd_dec_t x);
      case (f)
         FMT_BYTE:              return {x.nop, 18'h0, x.dest_file, x.file_addr};
         FMT_BIT:               return {x.nop, 8'h0, x.bit_mask, x.bit_pos, x.file_addr};
         FMT_LIT8:              return {x.nop, 9'h0, x.lit_w, x.literal};
         FMT_BRA11, FMT_BR8:    return {x.nop, 9'h0, x.br_rel, x.br_value};
         FMT_RET:               return {x.nop, 30'h0, x.shadow_restore};
         FMT_MOVFF, FMT_IDXMOV: return {x.nop, 7'h0, x.src_addr, x.dst_addr};
         FMT_LFSR:              return {x.nop, 7'h0, x.ptr_sel, x.lit_w, x.literal};
         FMT_GOTO, FMT_CALL:    return {x.nop, 9'h0, x.shadow_save, x.br_rel, x.literal};
         FMT_TBL:               return {x.nop, 28'h0, x.tbl_write, x.tmode};
         default:               return {x.nop, 31'h0};
      endcase
   endfunction

   function automatic ofd_dec_t expect_dec(ofd_fmt_t f, logic [15:0] a, logic [15:0] b,
                                           logic tw);
      ofd_dec_t e;
      e = '0;
      e.nop = a[15:12] == 4'hF || (two(f) && b[15:12] != 4'hF);
      e.file_addr = a[8] ? {bsel, a[7:0]} : {(a[7:0] < 8'h80) ? 4'h0 : 4'hF, a[7:0]};
      e.dest_file = a[9];
      e.bit_pos = a[11:9];
      e.bit_mask = 8'h01 << a[11:9];
      e.literal = f == FMT_LIT8 ? {12'h0, a[7:0]} :
                  f == FMT_LFSR ? {8'h0, a[3:0], b[7:0]} : {b[11:0], a[7:0]};
      e.lit_w = f == FMT_LIT8 ? LW_8 : f == FMT_LFSR ? LW_12 : LW_20;
      e.ptr_sel = a[5:4];
      e.br_rel = f == FMT_BRA11 || f == FMT_BR8;
      e.br_value = f == FMT_BRA11 ? 21'(signed'(a[10:0])) : 21'(signed'(a[7:0]));
      e.shadow_save = f == FMT_CALL && a[8];
      e.shadow_restore = a[0];
      e.src_addr = f == FMT_IDXMOV ? iptr[IDX] + 12'(a[6:0]) : a[11:0];
      e.dst_addr = f == FMT_IDXMOV ? iptr[IDX] + 12'(b[6:0]) : b[11:0];
      e.tmode = ofd_tmode_t'(a[1:0]);
      e.tbl_write = tw;
      return e;
   endfunction

   task automatic run(input ofd_fmt_t f, input logic [15:0] a, input logic [15:0] b,
                      input logic tw);
      ofd_dec_t e;
      ofd_fmt_t kf;
      e = expect_dec(f, a, b, tw);
      kf = e.nop ? FMT_NONE : f;
      @(posedge aclk);
      fv    <= 1'b1;
      fetch <= '{a, f, tw};
      if (two(f) && a[15:12] != 4'hF)
      begin
         @(posedge aclk);
         fetch <= '{b, f, tw};
      end
      @(posedge aclk);
      fv <= 1'b0;
      do
         @(posedge aclk);
      while (dec_valid !== 1'b1);
      chk(key(kf, dec), key(kf, e));
   endtask

   task automatic tbl(input logic [1:0] m, input logic tw, input logic [20:0] p);
      logic [20:0] acc, nxt;
      acc = m == 2'b11 ? p + 21'h1 : p;
      nxt = m == 2'b00 ? p : m == 2'b10 ? p - 21'h1 : p + 21'h1;
      axw(REG_TPTR, 32'(p), r);
      axw(REG_TLAT, 32'(p[7:0]), r);
      run(FMT_TBL, {14'h0, m}, 16'h0, tw);
      chk({prog_wr, prog_rd, 9'h0, paddr}, {tw, ~tw, 9'h0, acc});
      chk(32'(tptr), 32'(nxt));
      if (tw)
         chk(32'(wr_data), 32'(p[7:0]));
      if (!tw)
         @(posedge rd_valid);
      axr(REG_TLAT, d, r);
      chk(d, {24'h0, tw ? p[7:0] : acc[7:0] ^ 8'hA5});
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      void'($urandom(32'hFBF41380));
      {aresetn, awv, wv, bready, arv, rready, fv, fwe, fval} = '0;
      {awaddr, araddr, wdata, fetch} = '0;
      iptr = 48'({$urandom, $urandom});
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      bsel = 4'($urandom);
      axw(REG_BANK, 32'(bsel), r);
      chk(32'(r), 32'(RESP_OKAY));
      axr(REG_BANK, d, r);
      chk(d, 32'(bsel));
      axr(8'h20, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axw(8'h24, 32'hFFFFFFFF, r);
      chk(32'(r), 32'(RESP_SLVERR));
      $display("test registers done");
      // Bit 12 clear keeps first words off the marker
      for (i = 0; i < 60; i++)
         run(fl[i % 6], 16'($urandom) & 16'hEFFF, 16'h0, 1'b0);
      for (i = 0; i < 25; i++)
         run(tl[i % 5], 16'($urandom) & 16'hEFFF, 16'($urandom) | 16'hF000, 1'b0);
      run(FMT_BYTE, 16'hF0A5, 16'h0, 1'b0);
      run(FMT_MOVFF, 16'h0123, 16'h0456, 1'b0);
      $display("test decode done");
      for (i = 0; i < 8; i++)
         tbl(2'(i), i[2], 21'($urandom));
      tbl(2'b01, 1'b0, 21'h1FFFFF);
      tbl(2'b10, 1'b1, 21'h000000);
      $display("test table done");
      for (i = 0; i < 20; i++)
      begin
         @(posedge aclk);
         fwe  <= 5'($urandom);
         fval <= 5'($urandom);
         @(posedge aclk);
         ef  = (flags & ~fwe) | (fval & fwe);
         fwe <= 5'h0;
         @(posedge aclk);
         chk(32'(flags), 32'(ef));
      end
      $display("test flags done");
      results();
   end
endmodule // opcode_field_decoder_tb
